/* File: src/pmc_map.svh */
// Constants for the pluggable module control pins: timing counts and management map
// Summary of operation
// - Fault output low in normal operation, high once a laser fault is seen.
// - Transmitter on while laser_off_in low, init is done and no fault is latched; off otherwise, including high or open.
// - An undriven laser_off_in reads as disabled, so transmitter starts off.
// - The presence line is held low permanently to show the module is fitted.
// - Management bus clock comes from the host; the data line is two-way.
// - signal_lost_out high while received light is lost, low when it is present.
// - Identification bytes and live diagnostics are both readable over the bus.
// - Rx power, tx power, bias, supply and temperature monitors, either calibration.
// - Transmitter off within 10 us of disable, back on within 1 ms.
// - Fault flagged within 100 us; a disable held high for 10 us clears it.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ****************************************
// Clock and timing
// ****************************************
`define PMC_CLK_PERIOD_NS 4
`define PMC_T_RESET_NS 10000
`define PMC_T_INIT_MS 300
`define PMC_T_LOST_MAX_NS 100000
`define PMC_RST_CYC ((`PMC_T_RESET_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_INIT_CYC ((`PMC_T_INIT_MS * 1000000) / `PMC_CLK_PERIOD_NS)
`define PMC_LOST_MAX_CYC (`PMC_T_LOST_MAX_NS / `PMC_CLK_PERIOD_NS)
`define PMC_LOST_MARGIN 16

// ****************************************
// Management bus addresses and map
// ****************************************
`define PMC_ADDR_ID 7'h50
`define PMC_ADDR_DIAG 7'h51
`define PMC_ID_TYPE_BYTE 8'h00
`define PMC_ID_TYPE_VAL 8'h03
`define PMC_ID_DDM_BYTE 8'h5C
`define PMC_DDM_BIT_INT 5
`define PMC_DDM_BIT_EXT 4
`define PMC_DIAG_TEMP 8'h60
`define PMC_DIAG_VCC 8'h62
`define PMC_DIAG_BIAS 8'h64
`define PMC_DIAG_TXP 8'h66
`define PMC_DIAG_RXP 8'h68
`define PMC_DIAG_STAT 8'h6E
`define PMC_STAT_BIT_OFF 7
`define PMC_STAT_BIT_FLT 2
`define PMC_STAT_BIT_LOST 1

`endif

/* File: src/pmc_pkg.sv */
// Types shared by the pluggable module control pins design
package pmc_pkg;
  typedef logic [7:0] pmc_byte_t;
  typedef enum logic [2:0] {
    TWI_IDLE = 3'b000,
    TWI_ADDR = 3'b001,
    TWI_AACK = 3'b010,
    TWI_WORD = 3'b011,
    TWI_WACK = 3'b100,
    TWI_READ = 3'b101,
    TWI_RACK = 3'b110
  } pmc_twi_e;
endpackage

/* File: src/pmc_twi_slave.sv */
// Two-wire management bus target, oversampled on the system clock
`include "pmc_map.svh"
module pmc_twi_slave (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Synchronised bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Byte fetch from the memory map
  input wire pmc_pkg::pmc_byte_t rd_byte_i,
  output logic sel_diag_o,
  output pmc_pkg::pmc_byte_t ptr_o,
  // Request to pull the data line low
  output logic sda_low_o
);
  pmc_pkg::pmc_twi_e state;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] out_byte;
  logic is_read;
  logic first_word;
  logic master_ack;

  // ****************************************
  // Bus event detection
  // ****************************************
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire bus_start = scl_i & scl_q & sda_q & ~sda_i;
  wire bus_stop = scl_i & scl_q & ~sda_q & sda_i;
  wire addr_hit = (shreg[7:1] == `PMC_ADDR_ID) || (shreg[7:1] == `PMC_ADDR_DIAG);
  wire byte_done = (bit_cnt == 4'h8);

  // Previous levels for edge finding
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ****************************************
  // Protocol sequencer
  // ****************************************
  // Bits are taken on SCL rise, the data line changes only after SCL fall
  // target side
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= pmc_pkg::TWI_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      out_byte <= 8'h00;
      is_read <= 1'b0;
      first_word <= 1'b0;
      master_ack <= 1'b0;
      sel_diag_o <= 1'b0;
      ptr_o <= 8'h00;
      sda_low_o <= 1'b0;
    end else if (bus_start) begin
      // Repeated start keeps the pointer for random reads
      state <= pmc_pkg::TWI_ADDR;
      bit_cnt <= 4'h0;
      sda_low_o <= 1'b0;
    end else if (bus_stop) begin
      state <= pmc_pkg::TWI_IDLE;
      sda_low_o <= 1'b0;
    end else if (scl_rise) begin
      shreg <= {shreg[6:0], sda_i};
      if (state == pmc_pkg::TWI_ADDR || state == pmc_pkg::TWI_WORD) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      master_ack <= ~sda_i;
    end else if (scl_fall) begin
      unique case (state)
        pmc_pkg::TWI_IDLE: begin
          sda_low_o <= 1'b0;
        end
        pmc_pkg::TWI_ADDR: begin
          if (byte_done && addr_hit) begin
            sel_diag_o <= shreg[1];
            is_read <= shreg[0];
            sda_low_o <= 1'b1;
            state <= pmc_pkg::TWI_AACK;
          end else if (byte_done) begin
            state <= pmc_pkg::TWI_IDLE;
          end
        end
        pmc_pkg::TWI_AACK: begin
          bit_cnt <= 4'h0;
          first_word <= 1'b1;
          if (is_read) begin
            out_byte <= rd_byte_i;
            sda_low_o <= ~rd_byte_i[7];
            state <= pmc_pkg::TWI_READ;
          end else begin
            sda_low_o <= 1'b0;
            state <= pmc_pkg::TWI_WORD;
          end
        end
        pmc_pkg::TWI_WORD: begin
          // Later bytes of a write are acknowledged and only step the pointer on by one: the map is read-only
          if (byte_done) begin
            ptr_o <= first_word ? shreg : ptr_o + 8'h01;
            sda_low_o <= 1'b1;
            state <= pmc_pkg::TWI_WACK;
          end
        end
        pmc_pkg::TWI_WACK: begin
          sda_low_o <= 1'b0;
          bit_cnt <= 4'h0;
          first_word <= 1'b0;
          state <= pmc_pkg::TWI_WORD;
        end
        pmc_pkg::TWI_READ: begin
          if (bit_cnt == 4'h7) begin
            sda_low_o <= 1'b0;
            ptr_o <= ptr_o + 8'h01;
            state <= pmc_pkg::TWI_RACK;
          end else begin
            out_byte <= {out_byte[6:0], 1'b0};
            sda_low_o <= ~out_byte[6];
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        pmc_pkg::TWI_RACK: begin
          bit_cnt <= 4'h0;
          if (master_ack) begin
            out_byte <= rd_byte_i;
            sda_low_o <= ~rd_byte_i[7];
            state <= pmc_pkg::TWI_READ;
          end else begin
            state <= pmc_pkg::TWI_IDLE;
          end
        end
        default: begin
          state <= pmc_pkg::TWI_IDLE;
        end
      endcase
    end
  end
endmodule

/* File: src/pmc_top.sv */
// Control pins, fault latch, loss filter and management map of the pluggable module
`include "pmc_map.svh"
module pmc_top #(
  parameter int unsigned INIT_CYC = `PMC_INIT_CYC,
  parameter int unsigned LOST_CYC = `PMC_LOST_MAX_CYC - `PMC_LOST_MARGIN
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Host control pins
  input wire logic laser_off_in_i,
  output logic laser_fault_out_o,
  output logic signal_lost_out_o,
  output logic presence_tie_low_o,
  // Management bus pins
  input wire logic id_bus_clock_pin_i,
  input wire logic id_bus_data_pin_i,
  output logic id_bus_data_pin_o,
  output logic id_bus_data_pin_oe_n_o,
  // Optics side status
  input wire logic laser_fault_det_i,
  input wire logic rx_power_ok_i,
  output logic laser_en_o,
  // Monitor words, sampled on clk_sys_i
  input wire logic cal_external_i,
  input wire logic [15:0] temp_mon_i,
  input wire logic [15:0] vcc_mon_i,
  input wire logic [15:0] bias_mon_i,
  input wire logic [15:0] txp_mon_i,
  input wire logic [15:0] rxp_mon_i
);
  logic off_s1;
  logic off_s2;
  logic flt_s1;
  logic flt_s2;
  logic rxok_s1;
  logic rxok_s2;
  logic scl_s1;
  logic scl_s2;
  logic sda_s1;
  logic sda_s2;
  logic [31:0] init_cnt;
  logic init_done;
  logic [31:0] off_cnt;
  logic [31:0] lost_cnt;
  logic twi_sel_diag;
  pmc_pkg::pmc_byte_t twi_ptr;
  logic twi_sda_low;

  // Byte of a 16-bit monitor at a big-endian pair of addresses
  function automatic pmc_pkg::pmc_byte_t mon_byte(input logic [15:0] word,
                                                  input logic low_half);
    mon_byte = low_half ? word[7:0] : word[15:8];
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // open disable pin resets to the disabled level
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_s1 <= 1'b1;
      off_s2 <= 1'b1;
      flt_s1 <= 1'b0;
      flt_s2 <= 1'b0;
      rxok_s1 <= 1'b0;
      rxok_s2 <= 1'b0;
    end else begin
      off_s1 <= laser_off_in_i;
      off_s2 <= off_s1;
      flt_s1 <= laser_fault_det_i;
      flt_s2 <= flt_s1;
      rxok_s1 <= rx_power_ok_i;
      rxok_s2 <= rxok_s1;
    end
  end

  // Idle bus is high on both lines
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= id_bus_clock_pin_i;
      scl_s2 <= scl_s1;
      sda_s1 <= id_bus_data_pin_i;
      sda_s2 <= sda_s1;
    end
  end

  // ****************************************
  // Initialisation and fault latch
  // ****************************************
  wire next_init_done = (init_cnt >= INIT_CYC - 1);
  wire off_held = (off_cnt >= `PMC_RST_CYC - 1);
  wire fault_set = flt_s2 & init_done;
  wire fault_clr = off_held | ~init_done;
  // A fault seen in the clearing cycle is kept: set beats clear
  wire next_fault = fault_set | (laser_fault_out_o & ~fault_clr);
  // Light only after init, with no disable and no latched fault
  wire next_laser_en = init_done & ~off_s2 & ~next_fault;

  // Init timer stops once done; fault flag forced low until then
  // init window
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_cnt <= 32'h0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 32'h1;
      init_done <= next_init_done;
    end
  end

  // Disable high time, saturates so a long disable stays a reset
  // reset pulse width
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      off_cnt <= 32'h0;
    end else if (!off_s2) begin
      off_cnt <= 32'h0;
    end else if (!off_held) begin
      off_cnt <= off_cnt + 32'h1;
    end
  end

  // Fault latch and transmitter enable; disable acts in a few cycles
  // fault and enable
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      laser_fault_out_o <= 1'b0;
      laser_en_o <= 1'b0;
    end else begin
      laser_fault_out_o <= next_fault;
      laser_en_o <= next_laser_en;
    end
  end

  a_off_darkens: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    off_s2 |=> !laser_en_o)
    else $error("transmitter lit while disabled");

  a_off_pin_fast: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    laser_off_in_i [*3] ##1 laser_off_in_i |-> !laser_en_o)
    else $error("transmitter not off three cycles after disable");

  a_fault_flags: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (flt_s2 && init_done) |=> (laser_fault_out_o && !laser_en_o))
    else $error("fault not flagged after detection");

  a_fault_latches: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (laser_fault_out_o && !off_held && init_done) |=> laser_fault_out_o)
    else $error("fault dropped without a reset pulse");

  a_fault_resets: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ($fell(laser_fault_out_o) && init_done) |-> $past(off_cnt) >= `PMC_RST_CYC - 1)
    else $error("fault cleared by a short disable pulse");

  a_init_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !init_done |=> (!laser_en_o && !laser_fault_out_o))
    else $error("activity before initialisation ends");

  // ****************************************
  // Loss of signal filter
  // ****************************************
  // Only a disagreement lasting LOST_CYC cycles flips the output, so glitches vanish
  wire lost_differs = (rxok_s2 == signal_lost_out_o);
  wire lost_flip = lost_differs & (lost_cnt >= LOST_CYC - 1);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lost_cnt <= 32'h0;
      signal_lost_out_o <= 1'b1;
    end else if (!lost_differs || lost_flip) begin
      lost_cnt <= 32'h0;
      signal_lost_out_o <= signal_lost_out_o ^ lost_flip;
    end else begin
      lost_cnt <= lost_cnt + 32'h1;
    end
  end

  a_lost_filtered: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $changed(signal_lost_out_o) |-> $past(lost_cnt) == LOST_CYC - 1)
    else $error("loss output changed without full filter delay");

  a_lost_bounded: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    lost_cnt < LOST_CYC)
    else $error("loss filter overran its bound");

  // ****************************************
  // Management map
  // ****************************************
  wire [7:0] ddm_type = (8'h01 << `PMC_DDM_BIT_INT) & {8{~cal_external_i}}
                      | (8'h01 << `PMC_DDM_BIT_EXT) & {8{cal_external_i}};
  wire [7:0] status_byte = ({7'h00, off_s2} << `PMC_STAT_BIT_OFF)
                         | ({7'h00, laser_fault_out_o} << `PMC_STAT_BIT_FLT)
                         | ({7'h00, signal_lost_out_o} << `PMC_STAT_BIT_LOST);
  wire [7:0] ptr_pair = {twi_ptr[7:1], 1'b0};
  wire [7:0] id_byte = (twi_ptr == `PMC_ID_TYPE_BYTE) ? `PMC_ID_TYPE_VAL :
                       (twi_ptr == `PMC_ID_DDM_BYTE) ? ddm_type : 8'h00;
  wire [7:0] diag_byte =
      (ptr_pair == `PMC_DIAG_TEMP) ? mon_byte(temp_mon_i, twi_ptr[0]) :
      (ptr_pair == `PMC_DIAG_VCC) ? mon_byte(vcc_mon_i, twi_ptr[0]) :
      (ptr_pair == `PMC_DIAG_BIAS) ? mon_byte(bias_mon_i, twi_ptr[0]) :
      (ptr_pair == `PMC_DIAG_TXP) ? mon_byte(txp_mon_i, twi_ptr[0]) :
      (ptr_pair == `PMC_DIAG_RXP) ? mon_byte(rxp_mon_i, twi_ptr[0]) :
      (twi_ptr == `PMC_DIAG_STAT) ? status_byte : 8'h00;
  wire [7:0] map_byte = twi_sel_diag ? diag_byte : id_byte;

  pmc_twi_slave u_twi (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .scl_i(scl_s2),
    .sda_i(sda_s2),
    .rd_byte_i(map_byte),
    .sel_diag_o(twi_sel_diag),
    .ptr_o(twi_ptr),
    .sda_low_o(twi_sda_low)
  );

  // Open drain pins: only ever pull low; presence is a constant ground
  // pin drivers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      id_bus_data_pin_o <= 1'b0;
      id_bus_data_pin_oe_n_o <= 1'b1;
      presence_tie_low_o <= 1'b0;
    end else begin
      id_bus_data_pin_o <= 1'b0;
      id_bus_data_pin_oe_n_o <= ~twi_sda_low;
      presence_tie_low_o <= 1'b0;
    end
  end

  a_presence_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !presence_tie_low_o && !id_bus_data_pin_o)
    else $error("presence or data pin driven high");

  // Pin drive lags the sequencer by one flop, which lags the seen event by one more
  a_sda_follows: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $changed(id_bus_data_pin_oe_n_o) |->
      ($past(scl_s2, 3) && !$past(scl_s2, 2))
      || (($past(sda_s2, 2) != $past(sda_s2, 3)) && $past(scl_s2, 2)))
    else $error("data line changed away from a clock fall");
endmodule

/* File: verif/pmc_host_model.sv */
// Host board model: management bus master that clocks and pulls the data line
module pmc_host_model (
  // Bus lines
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Idle levels
  // ****************************************
  // host owns the clock
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // ****************************************
  // Bit level
  // ****************************************
  // clock held well below sampling rate; data moves only while clock low
  task automatic bit_out(input logic b);
    #12 sda_low_o = ~b;
    #12 scl_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask

  // data line released so the module can answer
  task automatic bit_in(output logic b);
    #12 sda_low_o = 1'b0;
    #12 scl_o = 1'b1;
    #12 b = sda_i;
    #12 scl_o = 1'b0;
  endtask

  // Start also serves as repeated start, so it raises the clock itself
  task automatic start_c;
    #12 sda_low_o = 1'b0;
    #12 scl_o = 1'b1;
    #24 sda_low_o = 1'b1;
    #24 scl_o = 1'b0;
  endtask

  // Stop leaves the clock standing high between frames
  task automatic stop_c;
    #12 sda_low_o = 1'b1;
    #12 scl_o = 1'b1;
    #24 sda_low_o = 1'b0;
    #24;
  endtask

  task automatic send(input logic [7:0] v, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_in(ack_n);
  endtask

  task automatic fetch(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
  endtask

  // ****************************************
  // Word read: pointer write, repeated start, two bytes, nack
  // ****************************************
  task automatic read_word(input logic [6:0] dev, input logic [7:0] ptr,
                           output logic [15:0] word, output logic acked);
    logic a0 = 1'b1;
    logic a1 = 1'b1;
    logic a2 = 1'b1;
    word = 16'h0000;
    start_c;
    send({dev, 1'b0}, a0);
    if (a0 === 1'b0) begin
      send(ptr, a1);
      start_c;
      send({dev, 1'b1}, a2);
      fetch(word[15:8], 1'b0);
      fetch(word[7:0], 1'b1);
    end
    stop_c;
    acked = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
  endtask
endmodule

/* File: verif/pmc_top_tb.sv */
// Self-checking bench for the pluggable module control pins
`include "pmc_map.svh"
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module pmc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals
  // ****************************************
  localparam int unsigned INIT_N = 20;
  localparam int unsigned LOST_N = 8;
  localparam logic [7:0] DPTR [5] = '{`PMC_DIAG_TEMP, `PMC_DIAG_VCC, `PMC_DIAG_BIAS,
                                      `PMC_DIAG_TXP, `PMC_DIAG_RXP};
  localparam logic [15:0] MON [5] = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081, 16'h92A3};
  logic clk_sys_i, resetn_i, laser_off_in_i, laser_fault_det_i, rx_power_ok_i;
  logic cal_external_i, laser_fault_out_o, signal_lost_out_o, presence_tie_low_o;
  logic laser_en_o, data_o, data_oe_n, scl, host_low, sda_wire;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Wired-AND data line with the host board pull-up
  assign sda_wire = ~host_low & (data_oe_n | data_o);

  pmc_top #(.INIT_CYC(INIT_N), .LOST_CYC(LOST_N)) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .laser_off_in_i(laser_off_in_i),
    .laser_fault_out_o(laser_fault_out_o), .signal_lost_out_o(signal_lost_out_o),
    .presence_tie_low_o(presence_tie_low_o), .id_bus_clock_pin_i(scl),
    .id_bus_data_pin_i(sda_wire), .id_bus_data_pin_o(data_o),
    .id_bus_data_pin_oe_n_o(data_oe_n), .laser_fault_det_i(laser_fault_det_i),
    .rx_power_ok_i(rx_power_ok_i), .laser_en_o(laser_en_o),
    .cal_external_i(cal_external_i), .temp_mon_i(MON[0]), .vcc_mon_i(MON[1]),
    .bias_mon_i(MON[2]), .txp_mon_i(MON[3]), .rxp_mon_i(MON[4]));

  pmc_host_model i_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_wire));

  // ****************************************
  // Clock, watchdog and verdict
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Whole run needs about 8300 cycles; a hang is cut off well beyond that
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_state;
    `CHK({laser_en_o, laser_fault_out_o, signal_lost_out_o}, 3'b001)
    `CHK({presence_tie_low_o, data_o, data_oe_n}, 3'b001)
  endtask

  // Pin left high as an open input: transmitter must stay off after init
  task automatic t_after_init;
    tick(INIT_N + 10);
    `CHK(laser_en_o, 1'b0)
    `CHK(laser_fault_out_o, 1'b0)
    `CHK(presence_tie_low_o, 1'b0)
  endtask

  task automatic t_enable;
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b0;
    tick(2);
    `CHK(laser_en_o, 1'b0)
    tick(1);
    `CHK(laser_en_o, 1'b1)
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b1;
    tick(3);
    `CHK(laser_en_o, 1'b0)
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b0;
    tick(4);
    `CHK(laser_en_o, 1'b1)
  endtask

  // Fault latches; a short disable pulse must not clear it, a long one must
  task automatic t_fault;
    @(posedge clk_sys_i);
    laser_fault_det_i <= 1'b1;
    tick(2);
    `CHK(laser_fault_out_o, 1'b0)
    tick(1);
    `CHK({laser_fault_out_o, laser_en_o}, 2'b10)
    @(posedge clk_sys_i);
    laser_fault_det_i <= 1'b0;
    tick(50);
    `CHK(laser_fault_out_o, 1'b1)
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b1;
    tick(100);
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b0;
    tick(20);
    `CHK({laser_fault_out_o, laser_en_o}, 2'b10)
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b1;
    tick(2490);
    `CHK(laser_fault_out_o, 1'b1)
    tick(20);
    `CHK(laser_fault_out_o, 1'b0)
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b0;
    tick(3);
    `CHK({laser_fault_out_o, laser_en_o}, 2'b01)
  endtask

  // Short glitch ignored, sustained change followed in both directions
  task automatic t_loss;
    `CHK(signal_lost_out_o, 1'b1)
    @(posedge clk_sys_i);
    rx_power_ok_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rx_power_ok_i <= 1'b0;
    tick(20);
    `CHK(signal_lost_out_o, 1'b1)
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys_i);
      rx_power_ok_i <= ~rx_power_ok_i;
      tick(LOST_N);
      `CHK(signal_lost_out_o, ~k[0])
      tick(LOST_N);
      `CHK(signal_lost_out_o, k[0])
    end
  endtask

  task automatic t_bus;
    logic [15:0] w;
    logic ok;
    logic [2:0] st;
    @(posedge clk_sys_i);
    laser_off_in_i <= 1'b1;
    tick(10);
    i_host.read_word(`PMC_ADDR_ID, `PMC_ID_TYPE_BYTE, w, ok);
    `CHK(ok, 1'b1)
    `CHK(w[15:8], `PMC_ID_TYPE_VAL)
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys_i);
      cal_external_i <= c[0];
      tick(4);
      i_host.read_word(`PMC_ADDR_ID, `PMC_ID_DDM_BYTE, w, ok);
      `CHK({w[8 + `PMC_DDM_BIT_INT], w[8 + `PMC_DDM_BIT_EXT]}, {~c[0], c[0]})
    end
    for (int i = 0; i < 5; i++) begin
      i_host.read_word(`PMC_ADDR_DIAG, DPTR[i], w, ok);
      `CHK(w, MON[i])
    end
    i_host.read_word(`PMC_ADDR_DIAG, `PMC_DIAG_STAT, w, ok);
    st = {w[8 + `PMC_STAT_BIT_OFF], w[8 + `PMC_STAT_BIT_FLT], w[8 + `PMC_STAT_BIT_LOST]};
    `CHK(st, 3'b100)
    i_host.read_word(7'h52, 8'h00, w, ok);
    `CHK(ok, 1'b0)
    `CHK({data_o, data_oe_n}, 2'b01)
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    resetn_i = 1'b0;
    laser_off_in_i = 1'b1;
    laser_fault_det_i = 1'b0;
    rx_power_ok_i = 1'b0;
    cal_external_i = 1'b0;
    tick(10);
    t_reset_state;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_after_init;
    t_enable;
    t_fault;
    t_loss;
    t_bus;
    print_verdict;
  end
endmodule
